// ===== hw/mtile_defines.svh
// Constants of the memory tile: register offsets, fields, resets and codes.
// Summary of operation
// R1: Tile holds 8192 data bits, 9216 with byte extras, shapes 8192x1 to 256x36.
// R2: Each port has separate read and write strobes gating its operations.
// R3: Packed mode splits the array into two independent 4.5 K single-port halves.
// R4: True dual-port allows read plus write, two reads or two writes per cycle.
// R5: Single-port and simple dual-port modes accept every width from 1 to 36.
// R6: True dual-port with unequal widths refuses the 32 and 36 bit widths.
// R7: Each port has two separate clock enables.
// R8: A low clock enable stops every operation of that port in that cycle; here ce_in stops reads and writes, ce_out only the output register.
// R9: Async clears reach only read-address and output registers, and output latches.
// R10: Reads and writes happen on rising clock edges only.
// R11: Same-port read during write shows old or new data, as configured.
// R12: Cross-port read of a written word shows old data or undefined, as configured.
// R13: Each byte carries an extra bit that is stored and never checked.
// R14: Contents can be preloaded from an initialization image in RAM and ROM use.
// R15: Byte enables mask bytes so that masked bytes are not written; the code ignores them at widths below 16.
// R16: FIFO and shift-register control logic lives in user logic outside.
// R17: Byte enables are active high, one per byte, bit zero the lowest byte.
// R18: The optional output register delays read data by exactly one cycle.
// R19: Without the read strobe the output keeps the last read value.
// R20: Outputs read zero after reset until the first enabled read.
`ifndef MTILE_DEFINES_SVH
`define MTILE_DEFINES_SVH
`define MTILE_OFF_CTRL 8'h00
`define MTILE_OFF_IADDR 8'h04
`define MTILE_OFF_IPAR 8'h08
`define MTILE_OFF_IDATA 8'h0C
`define MTILE_OFF_STAT 8'h10
`define MTILE_CTRL_RST 32'h0000_0000
`define MTILE_CTRL_MODE 2:0
`define MTILE_CTRL_WA 6:3
`define MTILE_CTRL_WB 10:7
`define MTILE_CTRL_OREGA 11
`define MTILE_CTRL_OREGB 12
`define MTILE_CTRL_NEW 13
`define MTILE_CTRL_DC 14
`define MTILE_CTRL_MASK 32'h0000_7FFF
`define MTILE_STAT_RA 12:0
`define MTILE_STAT_RB 28:16
`define MTILE_W_X1 4'h0
`define MTILE_W_X2 4'h1
`define MTILE_W_X4 4'h2
`define MTILE_W_X8 4'h3
`define MTILE_W_X9 4'h4
`define MTILE_W_X16 4'h5
`define MTILE_W_X18 4'h6
`define MTILE_W_X32 4'h7
`define MTILE_W_X36 4'h8
`define MTILE_WORDS 256
`define MTILE_DONT_CARE 36'hF_FFFF_FFFF
`define MTILE_RESP_OKAY 2'h0
`define MTILE_RESP_SLVERR 2'h2
`endif

// ===== hw/mtile_pkg.sv
// Types shared by the memory tile modules.
package mtile_pkg;
  typedef enum logic [2:0] {
    MTILE_SINGLE = 3'h0,
    MTILE_SIMPLE_DP = 3'h1,
    MTILE_TRUE_DP = 3'h2,
    MTILE_ROM = 3'h3,
    MTILE_PACKED = 3'h4
  } mtile_mode_e;
  typedef enum logic [1:0] {MTILE_WR_IDLE = 2'b01, MTILE_WR_RESP = 2'b10} mtile_wst_e;
  typedef logic [35:0] mtile_word_t;
  typedef logic [3:0] mtile_wcode_t;
  typedef logic [12:0] mtile_addr_t;
endpackage

// ===== hw/mtile_port.sv
// One access port of the memory tile: mapping, masks, read latch, output register.
`timescale 1ns/100ps
`include "mtile_defines.svh"
module mtile_port #(
  parameter logic PORT_ID = 1'b0
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic aclr_reg,
  input wire logic aclr_latch,
  input wire mtile_pkg::mtile_wcode_t wcode,
  input wire logic packed_mode,
  input wire logic oreg_en,
  input wire logic new_data,
  input wire logic dont_care,
  input wire logic wr_ok,
  input wire logic rd_ok,
  input wire logic ce_in,
  input wire logic ce_out,
  input wire logic rden,
  input wire logic wren,
  input wire mtile_pkg::mtile_addr_t addr,
  input wire logic [3:0] byteena,
  input wire mtile_pkg::mtile_word_t din,
  input wire mtile_pkg::mtile_word_t rd_word,
  input wire logic coll,
  output logic [7:0] word_idx,
  output logic wr_en,
  output mtile_pkg::mtile_word_t wr_mask,
  output mtile_pkg::mtile_word_t wr_bits,
  output mtile_pkg::mtile_word_t q,
  output mtile_pkg::mtile_addr_t rd_addr
);
  import mtile_pkg::*;
  logic [5:0] w;
  logic [5:0] off;
  logic [2:0] n;
  logic [17:0] pos;
  logic par;
  logic rd_go;
  logic q_clr;
  mtile_word_t rd_ext, new_ext, latch_nxt, latch_r, q_r, wlim;
  mtile_addr_t rd_addr_r;

  assign wr_en = ce_in && wren && wr_ok; // R2 R8 R10
  assign rd_go = ce_in && rden && rd_ok; // R2 R8 R10
  assign wlim = (36'h1 << w) - 36'h1;
  assign q_clr = aclr_reg || (aclr_latch && !oreg_en);
  assign q = q_r;
  assign rd_addr = rd_addr_r;

  // Width code to bit count, extra-bit use and address shift.
  always_comb begin // R1 R5
    case (wcode)
      `MTILE_W_X1: {w, par, n} = {6'd1, 1'b0, 3'd0};
      `MTILE_W_X2: {w, par, n} = {6'd2, 1'b0, 3'd1};
      `MTILE_W_X4: {w, par, n} = {6'd4, 1'b0, 3'd2};
      `MTILE_W_X8: {w, par, n} = {6'd8, 1'b0, 3'd3};
      `MTILE_W_X9: {w, par, n} = {6'd9, 1'b1, 3'd2};
      `MTILE_W_X16: {w, par, n} = {6'd16, 1'b0, 3'd4};
      `MTILE_W_X18: {w, par, n} = {6'd18, 1'b1, 3'd1};
      `MTILE_W_X32: {w, par, n} = {6'd32, 1'b0, 3'd5};
      default: {w, par, n} = {6'd36, 1'b1, 3'd0};
    endcase
    pos = {5'h00, addr} << n;
    if (par) begin
      word_idx = 8'(addr >> n);
      off = 6'(addr[1:0] & 2'((3'h1 << n) - 3'h1)) * w;
    end else begin
      word_idx = pos[12:5];
      off = {1'b0, pos[4:0]};
    end
    if (packed_mode) begin
      word_idx = {PORT_ID, word_idx[6:0]}; // R3
    end
  end

  // Data bits skip every ninth array bit unless the width uses the extra bits.
  always_comb begin
    int d;
    int b;
    int lane;
    d = 0;
    b = 0;
    lane = 0;
    rd_ext = '0;
    new_ext = '0;
    wr_mask = '0;
    wr_bits = '0;
    for (int j = 0; j < 36; j++) begin
      d = par ? j : j - j / 9; // R13
      b = d - int'(off);
      lane = par ? b / 9 : b / 8;
      if ((par || (j % 9 != 8)) && b >= 0 && b < int'(w)) begin
        rd_ext[b] = rd_word[j];
        wr_bits[j] = din[b];
        wr_mask[j] = wr_en && (wcode < `MTILE_W_X16 || byteena[lane]); // R15 R17
        new_ext[b] = wr_mask[j] ? din[b] : rd_word[j];
      end
    end
  end

  always_comb begin
    if (wr_en && new_data) begin
      latch_nxt = new_ext; // R11
    end else if (coll && dont_care) begin
      latch_nxt = `MTILE_DONT_CARE; // R12
    end else begin
      latch_nxt = rd_ext;
    end
  end

  always_ff @(posedge aclk or posedge aclr_latch) begin // R9
    if (aclr_latch) begin
      latch_r <= '0;
    end else if (!aresetn) begin
      latch_r <= '0; // R20
    end else if (rd_go) begin
      latch_r <= latch_nxt; // R19
    end
  end

  always_ff @(posedge aclk or posedge q_clr) begin // R9
    if (q_clr) begin
      q_r <= '0;
    end else if (!aresetn) begin
      q_r <= '0; // R20
    end else if (oreg_en) begin
      if (ce_out) begin
        q_r <= latch_r; // R7 R18
      end
    end else if (rd_go) begin
      q_r <= latch_nxt;
    end
  end

  always_ff @(posedge aclk or posedge aclr_reg) begin // R9
    if (aclr_reg) begin
      rd_addr_r <= '0;
    end else if (!aresetn) begin
      rd_addr_r <= '0;
    end else if (rd_go) begin
      rd_addr_r <= addr;
    end
  end

  a_ce_stops_ops: assert property ( // R8
    @(posedge aclk) disable iff (!aresetn || aclr_latch)
    !ce_in |-> !wr_en ##1 $stable(latch_r)) else $error("op with clock enable low");
  a_rden_keeps_out: assert property ( // R19
    @(posedge aclk) disable iff (!aresetn || aclr_latch)
    !rden |=> $stable(latch_r)) else $error("latch moved without read strobe");
  a_oreg_one_delay: assert property ( // R18
    @(posedge aclk) disable iff (!aresetn || aclr_reg || aclr_latch)
    oreg_en && ce_out |=> q_r == $past(latch_r)) else $error("output register delay wrong");
  a_byte_lane_mask: assert property ( // R15
    @(posedge aclk) disable iff (!aresetn)
    wr_en && wcode >= `MTILE_W_X16 && off == 6'd0 && !byteena[0] |-> !wr_mask[0])
    else $error("masked byte written");
  a_rdw_new_data: assert property ( // R11
    @(posedge aclk) disable iff (!aresetn || aclr_latch)
    rd_go && wr_en && new_data && byteena == 4'hF |=> latch_r == ($past(din) & $past(wlim)))
    else $error("new data not shown");
  a_mixed_dont_care: assert property ( // R12
    @(posedge aclk) disable iff (!aresetn || aclr_latch)
    rd_go && coll && dont_care && !(wr_en && new_data) |=> latch_r == `MTILE_DONT_CARE)
    else $error("cross-port collision not flagged");
  a_reset_zero_out: assert property ( // R20
    @(posedge aclk) !aresetn && !aclr_reg |=> q_r == '0 && latch_r == '0)
    else $error("output not zero after reset");
endmodule

// ===== hw/mtile_top.sv
// Memory tile top: two user ports, shared array and AXI4-Lite configuration slave.
//
// Chosen here: the address map and the AXI4-Lite interface to the registers.
`timescale 1ns/100ps
`include "mtile_defines.svh"
module mtile_top (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [7:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [7:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  input wire logic a_ce_in,
  input wire logic a_ce_out,
  input wire logic a_rden,
  input wire logic a_wren,
  input wire mtile_pkg::mtile_addr_t a_addr,
  input wire logic [3:0] a_byteena,
  input wire mtile_pkg::mtile_word_t a_din,
  input wire logic a_aclr_reg,
  input wire logic a_aclr_latch,
  output mtile_pkg::mtile_word_t a_q,
  input wire logic b_ce_in,
  input wire logic b_ce_out,
  input wire logic b_rden,
  input wire logic b_wren,
  input wire mtile_pkg::mtile_addr_t b_addr,
  input wire logic [3:0] b_byteena,
  input wire mtile_pkg::mtile_word_t b_din,
  input wire logic b_aclr_reg,
  input wire logic b_aclr_latch,
  output mtile_pkg::mtile_word_t b_q
);
  import mtile_pkg::*;

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  mtile_word_t mem [0:`MTILE_WORDS-1];
  logic [31:0] ctrl_r;
  logic [31:0] ctrl_nxt;
  logic [7:0] iaddr_r;
  logic [3:0] ipar_r;
  mtile_wst_e wst_r;
  logic aw_got_r;
  logic w_got_r;
  logic [7:0] waddr_r;
  logic [31:0] wdata_r;
  logic [3:0] wstrb_r;
  logic awready_r;
  logic wready_r;
  logic bvalid_r;
  logic [1:0] bresp_r;
  logic arready_r;
  logic rvalid_r;
  logic [31:0] rdata_r;
  logic [1:0] rresp_r;
  logic wr_go;
  logic wr_err;
  logic [31:0] rd_val;
  logic rd_err;
  logic init_we;
  mtile_word_t init_word;
  mtile_mode_e mode;
  logic packed_mode;
  logic [7:0] a_word;
  logic [7:0] b_word;
  logic a_we;
  logic b_we;
  mtile_word_t a_mask, a_bits, b_mask, b_bits;
  mtile_word_t a_merge, b_base, b_merge;
  mtile_addr_t a_rd_addr, b_rd_addr;

  assign awready = awready_r;
  assign wready = wready_r;
  assign bvalid = bvalid_r;
  assign bresp = bresp_r;
  assign arready = arready_r;
  assign rvalid = rvalid_r;
  assign rdata = rdata_r;
  assign rresp = rresp_r;

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic [31:0] strb_merge(input logic [31:0] old, input logic [31:0] nw,
                                             input logic [3:0] strb);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        r[i*8 +: 8] = nw[i*8 +: 8];
      end
    end
    return r;
  endfunction

  // Refuses undefined codes and width pairs that the array cannot serve.
  function automatic logic ctrl_ok(input logic [31:0] v);
    logic [3:0] wa;
    logic [3:0] wb;
    logic [2:0] m;
    logic ok;
    wa = v[`MTILE_CTRL_WA];
    wb = v[`MTILE_CTRL_WB];
    m = v[`MTILE_CTRL_MODE];
    ok = (m <= 3'(MTILE_PACKED)) && (wa <= `MTILE_W_X36) && (wb <= `MTILE_W_X36);
    if (m == 3'(MTILE_TRUE_DP) && wa != wb && (wa >= `MTILE_W_X32 || wb >= `MTILE_W_X32)) begin
      ok = 1'b0; // R6
    end
    if (m == 3'(MTILE_PACKED) && (wa > `MTILE_W_X18 || wb > `MTILE_W_X18)) begin
      ok = 1'b0; // R3
    end
    return ok;
  endfunction

  // ----------------------------------------------------------------
  // AXI4-Lite write channel
  // ----------------------------------------------------------------
  assign wr_go = (wst_r == MTILE_WR_IDLE) && aw_got_r && w_got_r;
  assign ctrl_nxt = strb_merge(ctrl_r, wdata_r, wstrb_r) & `MTILE_CTRL_MASK;

  always_comb begin
    if (waddr_r == `MTILE_OFF_CTRL) begin
      wr_err = !ctrl_ok(ctrl_nxt);
    end else if (waddr_r == `MTILE_OFF_IADDR) begin
      wr_err = 1'b0;
    end else if (waddr_r == `MTILE_OFF_IPAR) begin
      wr_err = 1'b0;
    end else if (waddr_r == `MTILE_OFF_IDATA) begin
      wr_err = 1'b0;
    end else begin
      wr_err = 1'b1;
    end
  end

  // Address and data are taken in either order; the response follows both.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wst_r <= MTILE_WR_IDLE;
      aw_got_r <= 1'b0;
      w_got_r <= 1'b0;
      awready_r <= 1'b0;
      wready_r <= 1'b0;
      bvalid_r <= 1'b0;
      bresp_r <= `MTILE_RESP_OKAY;
      waddr_r <= 8'h00;
      wdata_r <= 32'h0000_0000;
      wstrb_r <= 4'h0;
    end else begin
      case (wst_r)
        MTILE_WR_IDLE: begin
          if (awvalid && awready_r) begin
            aw_got_r <= 1'b1;
            waddr_r <= {awaddr[7:2], 2'b00};
            awready_r <= 1'b0;
          end else if (!aw_got_r) begin
            awready_r <= 1'b1;
          end
          if (wvalid && wready_r) begin
            w_got_r <= 1'b1;
            wdata_r <= wdata;
            wstrb_r <= wstrb;
            wready_r <= 1'b0;
          end else if (!w_got_r) begin
            wready_r <= 1'b1;
          end
          if (wr_go) begin
            bvalid_r <= 1'b1;
            bresp_r <= wr_err ? `MTILE_RESP_SLVERR : `MTILE_RESP_OKAY;
            wst_r <= MTILE_WR_RESP;
          end
        end
        MTILE_WR_RESP: begin
          if (bready) begin
            bvalid_r <= 1'b0;
            aw_got_r <= 1'b0;
            w_got_r <= 1'b0;
            wst_r <= MTILE_WR_IDLE;
          end
        end
        default: begin
          wst_r <= MTILE_WR_IDLE;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Configuration and preload registers
  // ----------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_r <= `MTILE_CTRL_RST;
    end else if (wr_go && waddr_r == `MTILE_OFF_CTRL && !wr_err) begin
      ctrl_r <= ctrl_nxt; // R6
    end
  end

  // Each data write stores one array word and steps the preload address.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      iaddr_r <= 8'h00;
      ipar_r <= 4'h0;
    end else if (wr_go && waddr_r == `MTILE_OFF_IADDR) begin
      iaddr_r <= 8'(strb_merge({24'h00_0000, iaddr_r}, wdata_r, wstrb_r));
    end else if (wr_go && waddr_r == `MTILE_OFF_IPAR) begin
      ipar_r <= 4'(strb_merge({28'h000_0000, ipar_r}, wdata_r, wstrb_r));
    end else if (init_we) begin
      iaddr_r <= iaddr_r + 8'h01; // R14
    end
  end

  assign init_we = wr_go && waddr_r == `MTILE_OFF_IDATA;

  always_comb begin
    init_word = '0;
    for (int j = 0; j < 36; j++) begin
      if (j % 9 == 8) begin
        init_word[j] = ipar_r[j / 9]; // R13
      end else begin
        init_word[j] = wdata_r[j - j / 9];
      end
    end
  end

  // ----------------------------------------------------------------
  // AXI4-Lite read channel
  // ----------------------------------------------------------------
  always_comb begin
    rd_val = 32'h0000_0000;
    rd_err = 1'b0;
    if (araddr[7:2] == `MTILE_OFF_CTRL >> 2) begin
      rd_val = ctrl_r;
    end else if (araddr[7:2] == `MTILE_OFF_IADDR >> 2) begin
      rd_val = {24'h00_0000, iaddr_r};
    end else if (araddr[7:2] == `MTILE_OFF_IPAR >> 2) begin
      rd_val = {28'h000_0000, ipar_r};
    end else if (araddr[7:2] == `MTILE_OFF_STAT >> 2) begin
      rd_val[`MTILE_STAT_RA] = a_rd_addr;
      rd_val[`MTILE_STAT_RB] = b_rd_addr;
    end else begin
      rd_err = 1'b1;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready_r <= 1'b0;
      rvalid_r <= 1'b0;
      rdata_r <= 32'h0000_0000;
      rresp_r <= `MTILE_RESP_OKAY;
    end else if (arvalid && arready_r) begin
      arready_r <= 1'b0;
      rvalid_r <= 1'b1;
      rdata_r <= rd_val;
      rresp_r <= rd_err ? `MTILE_RESP_SLVERR : `MTILE_RESP_OKAY;
    end else if (rvalid_r && rready) begin
      rvalid_r <= 1'b0;
    end else if (!rvalid_r) begin
      arready_r <= 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // Mode gating and ports
  // ----------------------------------------------------------------
  assign mode = mtile_mode_e'(ctrl_r[`MTILE_CTRL_MODE]);
  assign packed_mode = mode == MTILE_PACKED;

  mtile_port #(.PORT_ID(1'b0)) u_port_a (
    .aclk(aclk),
    .aresetn(aresetn),
    .aclr_reg(a_aclr_reg),
    .aclr_latch(a_aclr_latch),
    .wcode(ctrl_r[`MTILE_CTRL_WA]),
    .packed_mode(packed_mode),
    .oreg_en(ctrl_r[`MTILE_CTRL_OREGA]),
    .new_data(ctrl_r[`MTILE_CTRL_NEW]),
    .dont_care(ctrl_r[`MTILE_CTRL_DC]),
    .wr_ok(mode != MTILE_ROM),
    .rd_ok(mode != MTILE_SIMPLE_DP),
    .ce_in(a_ce_in),
    .ce_out(a_ce_out),
    .rden(a_rden),
    .wren(a_wren),
    .addr(a_addr),
    .byteena(a_byteena),
    .din(a_din),
    .rd_word(mem[a_word]),
    .coll(b_we && b_word == a_word),
    .word_idx(a_word),
    .wr_en(a_we),
    .wr_mask(a_mask),
    .wr_bits(a_bits),
    .q(a_q),
    .rd_addr(a_rd_addr)
  );

  mtile_port #(.PORT_ID(1'b1)) u_port_b (
    .aclk(aclk),
    .aresetn(aresetn),
    .aclr_reg(b_aclr_reg),
    .aclr_latch(b_aclr_latch),
    .wcode(ctrl_r[`MTILE_CTRL_WB]),
    .packed_mode(packed_mode),
    .oreg_en(ctrl_r[`MTILE_CTRL_OREGB]),
    .new_data(ctrl_r[`MTILE_CTRL_NEW]),
    .dont_care(ctrl_r[`MTILE_CTRL_DC]),
    .wr_ok(mode == MTILE_TRUE_DP || packed_mode),
    .rd_ok(mode != MTILE_SINGLE),
    .ce_in(b_ce_in),
    .ce_out(b_ce_out),
    .rden(b_rden),
    .wren(b_wren),
    .addr(b_addr),
    .byteena(b_byteena),
    .din(b_din),
    .rd_word(mem[b_word]),
    .coll(a_we && a_word == b_word),
    .word_idx(b_word),
    .wr_en(b_we),
    .wr_mask(b_mask),
    .wr_bits(b_bits),
    .q(b_q),
    .rd_addr(b_rd_addr)
  );

  // ----------------------------------------------------------------
  // Shared array
  // ----------------------------------------------------------------
  // Two writes to one word merge; port B wins on bits both ports write.
  assign a_merge = (mem[a_word] & ~a_mask) | (a_bits & a_mask);
  assign b_base = (a_we && a_word == b_word) ? a_merge : mem[b_word];
  assign b_merge = (b_base & ~b_mask) | (b_bits & b_mask);

  always_ff @(posedge aclk) begin // R10
    if (init_we) begin
      mem[iaddr_r] <= init_word; // R14
    end else begin
      if (a_we) begin
        mem[a_word] <= a_merge; // R4 R15
      end
      if (b_we) begin
        mem[b_word] <= b_merge; // R4 R15
      end
    end
  end

  a_packed_halves: assert property ( // R3
    @(posedge aclk) disable iff (!aresetn)
    packed_mode |-> !a_word[7] && b_word[7]) else $error("packed halves overlap");
  a_ctrl_refuse_bad: assert property ( // R6
    @(posedge aclk) disable iff (!aresetn)
    wr_go && waddr_r == `MTILE_OFF_CTRL && !ctrl_ok(ctrl_nxt)
    |=> $stable(ctrl_r) && bvalid_r && bresp_r == `MTILE_RESP_SLVERR)
    else $error("illegal config accepted");
  a_rom_no_write: assert property ( // R14
    @(posedge aclk) disable iff (!aresetn)
    mode == MTILE_ROM |-> !a_we && !b_we) else $error("write in ROM mode");
  a_bresp_holds: assert property (
    @(posedge aclk) disable iff (!aresetn)
    bvalid_r && !bready |=> bvalid_r && $stable(bresp_r)) else $error("bvalid dropped");
  a_rvalid_holds: assert property (
    @(posedge aclk) disable iff (!aresetn)
    rvalid_r && !rready |=> rvalid_r && $stable(rdata_r)) else $error("rvalid dropped");
  a_read_answer: assert property (
    @(posedge aclk) disable iff (!aresetn)
    arvalid && arready_r |=> rvalid_r) else $error("read answer late");
endmodule

// ===== sim/mtile_user.sv
// User-logic model that drives one memory port of the tile.
`timescale 1ns/100ps
module mtile_user (
  input wire logic aclk,
  output logic ce_in,
  output logic ce_out,
  output logic rden,
  output logic wren,
  output mtile_pkg::mtile_addr_t addr,
  output logic [3:0] byteena,
  output mtile_pkg::mtile_word_t din
);
  import mtile_pkg::*;
  initial begin
    {ce_in, ce_out, rden, wren} = 4'h C;
    addr = '0;
    byteena = 4'hF;
    din = '0;
  end
  // Issues one access, then releases the strobes and lets address and data wander.
  task automatic op(input logic ce, input logic w, input logic r, input mtile_addr_t a,
    input mtile_word_t d, input logic [3:0] be);
    ce_in <= ce;
    wren <= w;
    rden <= r;
    addr <= a;
    din <= d;
    byteena <= be;
    @(posedge aclk);
    ce_in <= 1'b1;
    wren <= 1'b0;
    rden <= 1'b0;
    addr <= ~a;
    din <= ~d;
    @(posedge aclk);
  endtask
  // Drives the output-register clock enable and lets one edge pass.
  task automatic stall(input logic co);
    ce_out <= co;
    @(posedge aclk);
  endtask
endmodule

// ===== sim/tb_top.sv
// Self-checking bench of the memory tile with two user-logic port models.
`timescale 1ns/100ps
`define CHK(g, e) begin check_count++; if ((g) !== (e)) begin err_count++; \
  $display("BAD %0t %h %h", $time, g, e); end end
module tb_top;
  import mtile_pkg::*;
  logic aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready;
  logic arvalid, arready, rvalid, rready, a_aclr_reg, a_aclr_latch, b_aclr_reg, b_aclr_latch;
  logic [7:0] awaddr, araddr;
  logic [31:0] wdata, rdata;
  logic [3:0] wstrb, a_byteena, b_byteena;
  logic [1:0] bresp, rresp;
  logic a_ce_in, a_ce_out, a_rden, a_wren, b_ce_in, b_ce_out, b_rden, b_wren;
  mtile_addr_t a_addr, b_addr;
  mtile_word_t a_din, b_din, a_q, b_q, d, last;
  mtile_word_t mem [256];
  logic [31:0] bad [4] = '{32'h5, 32'h4A, 32'h3C2, 32'h44};
  int err_count, check_count, cyc, j;
  mtile_top uut (.*);
  mtile_user ua (.aclk(aclk), .ce_in(a_ce_in), .ce_out(a_ce_out), .rden(a_rden),
    .wren(a_wren), .addr(a_addr), .byteena(a_byteena), .din(a_din));
  mtile_user ub (.aclk(aclk), .ce_in(b_ce_in), .ce_out(b_ce_out), .rden(b_rden),
    .wren(b_wren), .addr(b_addr), .byteena(b_byteena), .din(b_din));
  initial begin
    aclk = 1'b0;
    forever #12.5 aclk = ~aclk;
  end
  always @(posedge aclk) begin
    cyc++;
    if (cyc == 3000) begin
      err_count++;
      summarize();
    end
  end
  task automatic summarize;
    if (err_count == 0 && check_count > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  function automatic mtile_word_t merge(mtile_word_t o, mtile_word_t n, logic [3:0] be);
    mtile_word_t m;
    m = {{9{be[3]}}, {9{be[2]}}, {9{be[1]}}, {9{be[0]}}};
    return (o & ~m) | (n & m);
  endfunction
  function automatic mtile_word_t pack9(logic [3:0] p, logic [31:0] v);
    return {p[3], v[31:24], p[2], v[23:16], p[1], v[15:8], p[0], v[7:0]};
  endfunction
  task automatic axw(input logic [7:0] ad, input logic [31:0] v, input logic [1:0] er);
    bit ka, kw;
    ka = 0;
    kw = 0;
    awaddr <= ad;
    wdata <= v;
    wstrb <= 4'hF;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge aclk);
      ka |= awready;
      kw |= wready;
      if (ka) awvalid <= 1'b0;
      if (kw) wvalid <= 1'b0;
    end while (!(ka && kw));
    do @(posedge aclk); while (!bvalid);
    bready <= 1'b0;
    `CHK(bresp, er)
    @(posedge aclk);
  endtask
  task automatic axr(input logic [7:0] ad, input logic [31:0] ev, input logic [1:0] er);
    araddr <= ad;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do @(posedge aclk); while (!arready);
    arvalid <= 1'b0;
    do @(posedge aclk); while (!rvalid);
    rready <= 1'b0;
    `CHK(rresp, er)
    `CHK(rdata, ev)
    @(posedge aclk);
  endtask
  task automatic rd_a(input int w);
    ua.op(1, 0, 1, 13'(w), '0, 4'hF);
    `CHK(a_q, mem[w])
  endtask
  // ----
  // Stimulus
  // ----
  initial begin
    {aresetn, awvalid, wvalid, bready, arvalid, rready} = '0;
    {a_aclr_reg, a_aclr_latch, b_aclr_reg, b_aclr_latch} = '0;
    {awaddr, araddr, wdata, wstrb} = '0;
    void'($urandom(32'h7f91c4b9));
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    `CHK(a_q | b_q, 36'h0)
    axw(8'h00, 32'h442, 2'h0);
    foreach (bad[k]) axw(8'h00, bad[k], 2'h2);
    axr(8'h00, 32'h442, 2'h0);
    axr(8'h40, 32'h0, 2'h2);
    axw(8'h04, 32'h7, 2'h0);
    axw(8'h08, 32'hA, 2'h0);
    axw(8'h0C, 32'h1234_5678, 2'h0);
    mem[7] = pack9(4'hA, 32'h1234_5678);
    rd_a(7);
    d = mtile_word_t'({$urandom, $urandom});
    ua.op(1, 1, 0, 13'h7, d, 4'hA);
    mem[7] = merge(mem[7], d, 4'hA);
    rd_a(7);
    ua.op(0, 1, 1, 13'h7, ~d, 4'hF);
    `CHK(a_q, mem[7])
    rd_a(7);
    for (int i = 1; i < 16; i++) begin
      d = mtile_word_t'({$urandom, $urandom});
      j = 16 + (i + 1) / 2;
      last = b_q;
      fork
        ua.op(1, 1, 0, 13'(i), d, 4'hF);
        ub.op(1, i[0], !i[0], 13'(j), ~d, 4'hF);
      join
      mem[i] = d;
      if (i[0]) mem[j] = ~d;
      `CHK(b_q, i[0] ? last : mem[j])
    end
    fork
      ua.op(1, 0, 1, 13'h3, d, 4'hF);
      ub.op(1, 0, 1, 13'h4, d, 4'hF);
    join
    `CHK({a_q, b_q}, {mem[3], mem[4]})
    d = ~mem[2];
    fork
      ua.op(1, 1, 1, 13'h2, d, 4'hF);
      ub.op(1, 0, 1, 13'h2, d, 4'hF);
    join
    `CHK({a_q, b_q}, {mem[2], mem[2]})
    mem[2] = d;
    a_aclr_latch <= 1'b1;
    @(posedge aclk);
    a_aclr_latch <= 1'b0;
    `CHK(a_q, 36'h0)
    axw(8'h00, 32'hC42, 2'h0);
    ua.op(1, 0, 1, 13'h3, d, 4'hF);
    ua.op(1, 0, 1, 13'h4, d, 4'hF);
    `CHK(a_q, mem[3])
    @(posedge aclk);
    `CHK(a_q, mem[4])
    ua.stall(1'b0);
    ua.op(1, 0, 1, 13'h3, d, 4'hF);
    `CHK(a_q, mem[4])
    ua.stall(1'b1);
    a_aclr_reg <= 1'b1;
    @(posedge aclk);
    a_aclr_reg <= 1'b0;
    `CHK(a_q, 36'h0)
    axw(8'h00, 32'h2442, 2'h0);
    d = ~mem[5];
    ua.op(1, 1, 1, 13'h5, d, 4'hF);
    `CHK(a_q, d)
    axw(8'h00, 32'h4442, 2'h0);
    fork
      ua.op(1, 1, 0, 13'h6, d, 4'hF);
      ub.op(1, 0, 1, 13'h6, d, 4'hF);
    join
    mem[6] = d;
    `CHK(b_q, 36'hF_FFFF_FFFF)
    axw(8'h00, 32'h334, 2'h0);
    last = ~d;
    fork
      ua.op(1, 1, 0, 13'h1, d, 4'hF);
      ub.op(1, 1, 0, 13'h1, last, 4'hF);
    join
    fork
      ua.op(1, 0, 1, 13'h1, d, 4'hF);
      ub.op(1, 0, 1, 13'h1, d, 4'hF);
    join
    `CHK({a_q, b_q}, {36'(d[17:0]), 36'(last[17:0])})
    axw(8'h00, 32'h1B, 2'h0);
    ua.op(1, 1, 0, 13'h1D, '0, 4'hF);
    ua.op(1, 0, 1, 13'h1D, '0, 4'hF);
    `CHK(a_q, 36'(mem[7][16:9]))
    axr(8'h10, 32'h0001_001D, 2'h0);
    summarize();
  end
endmodule
